// ---- gdp_ctl_model.sv ----
// Behavioural memory controller model driving the front end's pins.
`timescale 1ns/10ps
module gdp_ctl_model (
    input  wire logic        aclk,
    output logic             sys_clock_pair,
    output logic             clk_gate,
    output logic             chip_sel_n,
    output logic             row_strobe_n,
    output logic             col_strobe_n,
    output logic             write_cmd_n,
    output logic [12:0]      addr_in,
    output logic [1:0]       bank_select,
    output logic [15:0]      dq_in,
    input  wire logic [15:0] dq_out,
    input  wire logic [15:0] dq_oe_n,
    output logic [1:0]       byte_strobe_in,
    input  wire logic [1:0]  byte_strobe_out,
    input  wire logic [1:0]  byte_strobe_oe_n,
    output logic [1:0]       write_byte_mask
);
    logic [15:0] dq_drv = 16'h0;
    logic [1:0]  dqs_drv = 2'h0;
    logic [15:0] seen_dq;
    logic        seen_oe;
    logic [1:0]  seen_dqs;
    // Each wire carries the device's value where it drives, else ours.
    assign dq_in = (dq_drv & dq_oe_n) | (dq_out & ~dq_oe_n);
    assign byte_strobe_in = (dqs_drv & byte_strobe_oe_n) | (byte_strobe_out & ~byte_strobe_oe_n);
    initial begin
        sys_clock_pair = 1'b0;
        clk_gate = 1'b1;
        {chip_sel_n, row_strobe_n, col_strobe_n, write_cmd_n} = 4'hf;
        addr_in = 13'h0;
        bank_select = 2'h0;
        write_byte_mask = 2'h0;
    end
    // One clock half is four aclk; the clock stands still outside halves.
    task automatic half(input logic tog);
        @(posedge aclk) sys_clock_pair <= ~sys_clock_pair;
        @(posedge aclk) if (tog) dqs_drv <= ~dqs_drv;
        @(posedge aclk);
        seen_dq = dq_out;
        // Any enable still high shows the bus as released.
        seen_oe = |{dq_oe_n, byte_strobe_oe_n};
        seen_dqs = byte_strobe_out;
        @(posedge aclk);
    endtask : half
    task automatic issue(input logic [3:0] c, input logic [12:0] a, input logic [1:0] b,
                         input logic g);
        {chip_sel_n, row_strobe_n, col_strobe_n, write_cmd_n} <= c;
        addr_in <= a;
        bank_select <= b;
        clk_gate <= g;
        half(1'b0);
        {chip_sel_n, row_strobe_n, col_strobe_n, write_cmd_n} <= 4'hf;
        addr_in <= ~a;
        half(1'b0);
    endtask : issue
    task automatic write(input logic [15:0] d, input logic [1:0] m);
        dq_drv <= d;
        write_byte_mask <= m;
        half(1'b1);
    endtask : write
    // Released data lines show the inverse of their last value.
    task automatic wr_end();
        dq_drv <= ~dq_drv;
        write_byte_mask <= 2'h3;
    endtask : wr_end
    task automatic lift();
        clk_gate <= 1'b1;
    endtask : lift
endmodule : gdp_ctl_model

// ---- gdp_front_end.sv ----
// DRAM pin front end: power states, mode options, bursts and register slave.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module gdp_front_end #(
    parameter int ROW_BITS = 13,
    parameter int COL_BITS = 9
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        sys_clock_pair,
    input  wire logic        clk_gate,
    input  wire logic        chip_sel_n,
    input  wire logic        row_strobe_n,
    input  wire logic        col_strobe_n,
    input  wire logic        write_cmd_n,
    input  wire logic [12:0] addr_in,
    input  wire logic [1:0]  bank_select,
    input  wire logic [15:0] dq_in,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe_n,
    input  wire logic [1:0]  byte_strobe_in,
    output logic [1:0]       byte_strobe_out,
    output logic [1:0]       byte_strobe_oe_n,
    input  wire logic [1:0]  write_byte_mask
);
    localparam int DEPTH = 4 << (ROW_BITS + COL_BITS);
    localparam int AW    = 2 + ROW_BITS + COL_BITS;

    if (ROW_BITS > gdp_pkg::ROW_W || COL_BITS > gdp_pkg::COL_W || COL_BITS < 3) begin : g_chk
        $error("gdp_front_end: unsupported address widths");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic gdp_pkg::gdp_cmd_e decode(input gdp_pkg::gdp_pin_s p);
        if (p.cs_n) begin
            return gdp_pkg::CMD_NOP;
        end
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h0: return gdp_pkg::CMD_MODE_REG_SET;
            3'h1: return gdp_pkg::CMD_REFRESH;
            3'h2: return gdp_pkg::CMD_PRECHARGE;
            3'h3: return gdp_pkg::CMD_ACTIVATE;
            3'h4: return gdp_pkg::CMD_WRITE;
            3'h5: return gdp_pkg::CMD_READ;
            3'h6: return gdp_pkg::CMD_STOP;
            default: return gdp_pkg::CMD_NOP;
        endcase
    endfunction : decode

    function automatic logic [3:0] beats(input logic [2:0] code);
        if (code == gdp_pkg::BL2_CODE) begin
            return 4'h2;
        end else if (code == gdp_pkg::BL4_CODE) begin
            return 4'h4;
        end
        return 4'h8;
    endfunction : beats

    function automatic logic [3:0] lat_half(input logic [2:0] code);
        return (code == gdp_pkg::CL25_CODE) ? gdp_pkg::LAT25_HALF : gdp_pkg::LAT3_HALF;
    endfunction : lat_half

    // Burst wraps inside the block of bl columns that holds the start column.
    function automatic logic [gdp_pkg::COL_W-1:0] burst_col(
        input logic [gdp_pkg::COL_W-1:0] start,
        input logic [3:0]                beat,
        input gdp_pkg::gdp_mode_s        m);
        logic [2:0] msk;
        logic [2:0] off;
        msk = 3'(beats(m.bl) - 4'h1);
        off = m.bt ? (start[2:0] ^ beat[2:0]) : (start[2:0] + beat[2:0]);
        return {start[gdp_pkg::COL_W-1:3], (start[2:0] & ~msk) | (off & msk)};
    endfunction : burst_col

    function automatic logic [AW-1:0] mem_idx(
        input logic [1:0]                bank,
        input logic [gdp_pkg::ROW_W-1:0] row,
        input logic [gdp_pkg::COL_W-1:0] col);
        return {bank, row[ROW_BITS-1:0], col[COL_BITS-1:0]};
    endfunction : mem_idx

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    gdp_pkg::gdp_state_s r;
    gdp_pkg::gdp_state_s next_r;
    logic [1:0][7:0]     mem [DEPTH];
    logic [1:0]          wr_en;
    logic [1:0][AW-1:0]  wr_addr;
    logic [1:0][7:0]     wr_byte;
    logic                sys_rise;
    logic                sys_edge;
    gdp_pkg::gdp_cmd_e   cmd;
    logic [3:0]          lat;
    logic [3:0]          bl;
    logic [3:0]          ne;
    logic [1:0]          sedge;
    logic [1:0][7:0]     rd_word;

    assign lat     = lat_half(r.mode.lat_code);
    assign bl      = beats(r.mode.bl);
    assign rd_word = mem[mem_idx(r.rd_bank, r.rd_row, burst_col(r.rd_col, r.rd_beat, r.mode))];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        wr_en   = '0;
        wr_addr = '0;
        wr_byte = '0;
        ne      = r.rd_edges;
        next_r.sync1 = '{sys_clock_pair, clk_gate, chip_sel_n, row_strobe_n, col_strobe_n,
                         write_cmd_n, addr_in, bank_select, dq_in, byte_strobe_in,
                         write_byte_mask};
        next_r.sync2    = r.sync1;
        next_r.sys_clk_prev = r.sync2.sys_clk;
        next_r.dqs_prev = r.sync2.dqs;
        // The system clock is blind while in self-refresh.
        sys_rise = r.sync2.sys_clk & ~r.sys_clk_prev & (r.pwr != gdp_pkg::PWR_SELF);
        sys_edge = (r.sync2.sys_clk ^ r.sys_clk_prev) & (r.pwr == gdp_pkg::PWR_ACTIVE);
        sedge   = (r.sync2.dqs ^ r.dqs_prev) & {2{r.pwr == gdp_pkg::PWR_ACTIVE}};
        cmd     = (sys_rise && r.pwr == gdp_pkg::PWR_ACTIVE) ? decode(r.sync2)
                                                             : gdp_pkg::CMD_NOP;

        // Register bus: write address and data taken in either order.
        if (awvalid && awready) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_r.w_got   = 1'b1;
            next_r.w_data  = wdata;
            next_r.w_strb0 = wstrb[0];
        end
        if (r.aw_got && r.w_got) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = gdp_pkg::RESP_OKAY;
            if (r.aw_addr == gdp_pkg::MODE_OFS) begin
                if (r.w_strb0) begin
                    next_r.mode = r.w_data[6:0];
                end
            end else if (r.aw_addr != gdp_pkg::STATUS_OFS && r.aw_addr != gdp_pkg::REFCNT_OFS) begin
                next_r.bresp = gdp_pkg::RESP_ERR;
            end
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = gdp_pkg::RESP_OKAY;
            if (araddr == gdp_pkg::MODE_OFS) begin
                next_r.rdata = {25'h0, r.mode};
            end else if (araddr == gdp_pkg::STATUS_OFS) begin
                next_r.rdata = {28'h0, r.wr_act, r.rd_act, r.pwr};
            end else if (araddr == gdp_pkg::REFCNT_OFS) begin
                next_r.rdata = {16'h0, r.ref_cnt};
            end else begin
                next_r.rdata = 32'h0;
                next_r.rresp = gdp_pkg::RESP_ERR;
            end
        end

        // Power state.
        case (r.pwr)
            gdp_pkg::PWR_ACTIVE: begin
                if (sys_rise && !r.sync2.cke) begin
                    next_r.pwr = (cmd == gdp_pkg::CMD_REFRESH) ? gdp_pkg::PWR_SELF
                                                               : gdp_pkg::PWR_DOWN;
                end
            end
            gdp_pkg::PWR_DOWN: begin
                if (sys_rise && r.sync2.cke) begin
                    next_r.pwr = gdp_pkg::PWR_ACTIVE;
                end
            end
            default: begin
                if (r.sync2.cke) begin
                    next_r.pwr = gdp_pkg::PWR_ACTIVE;
                end
            end
        endcase

        // Write beats: each lane follows its own strobe, both edges.
        for (int l = 0; l < 2; l++) begin
            if (r.wr_act && sedge[l] && r.wr_beat[l] < bl) begin
                wr_en[l]   = ~r.sync2.mask[l];
                wr_addr[l] = mem_idx(r.wr_bank, r.wr_row, burst_col(r.wr_col, r.wr_beat[l], r.mode));
                wr_byte[l] = r.sync2.dq[8*l +: 8];
                next_r.wr_beat[l] = r.wr_beat[l] + 4'h1;
            end
        end
        if (next_r.wr_beat[0] >= bl && next_r.wr_beat[1] >= bl) begin
            next_r.wr_act = 1'b0;
        end

        // Read beats: launched on system clock edges after the latency.
        if (r.rd_act && sys_edge) begin
            ne = (r.rd_edges < lat) ? r.rd_edges + 4'h1 : r.rd_edges;
            next_r.rd_edges = ne;
            if (ne >= lat) begin
                if (r.rd_beat < bl) begin
                    next_r.drv     = 1'b1;
                    next_r.dq_out  = rd_word;
                    next_r.dqs_out = {2{~r.rd_beat[0]}};
                    next_r.rd_beat = r.rd_beat + 4'h1;
                end else begin
                    next_r.drv    = 1'b0;
                    next_r.rd_act = 1'b0;
                end
            end
        end

        // Commands; a mode set from the pins wins over a bus write.
        case (cmd)
            gdp_pkg::CMD_MODE_REG_SET: begin
                if (r.sync2.bank == 2'h0) begin
                    next_r.mode = r.sync2.addr[6:0];
                end
            end
            gdp_pkg::CMD_REFRESH: begin
                next_r.ref_cnt = r.ref_cnt + 16'h1;
            end
            gdp_pkg::CMD_ACTIVATE: begin
                next_r.open_row[r.sync2.bank] = r.sync2.addr;
            end
            gdp_pkg::CMD_WRITE: begin
                next_r.wr_act  = 1'b1;
                next_r.wr_bank = r.sync2.bank;
                next_r.wr_row  = r.open_row[r.sync2.bank];
                next_r.wr_col  = r.sync2.addr[gdp_pkg::COL_W-1:0];
                next_r.wr_beat = '0;
            end
            gdp_pkg::CMD_READ: begin
                next_r.rd_act   = 1'b1;
                next_r.rd_bank  = r.sync2.bank;
                next_r.rd_row   = r.open_row[r.sync2.bank];
                next_r.rd_col   = r.sync2.addr[gdp_pkg::COL_W-1:0];
                next_r.rd_edges = 4'h0;
                next_r.rd_beat  = 4'h0;
                next_r.drv      = 1'b0;
            end
            gdp_pkg::CMD_STOP: begin
                next_r.rd_act = 1'b0;
                next_r.drv    = 1'b0;
            end
            default: begin
            end
        endcase
        // A low gate releases the outputs at once.
        next_r.oe_n = ~(next_r.drv & r.sync2.cke);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r      <= '0;
            r.mode <= gdp_pkg::MODE_RESET;
            r.oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge aclk) begin
        for (int l = 0; l < 2; l++) begin
            if (wr_en[l]) begin
                mem[wr_addr[l]][l] <= wr_byte[l];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign awready          = ~r.aw_got & ~r.bvalid;
    assign wready           = ~r.w_got & ~r.bvalid;
    assign bvalid           = r.bvalid;
    assign bresp            = r.bresp;
    assign arready          = ~r.rvalid;
    assign rvalid           = r.rvalid;
    assign rdata            = r.rdata;
    assign rresp            = r.rresp;
    assign dq_out           = r.dq_out;
    assign dq_oe_n          = {16{r.oe_n}};
    assign byte_strobe_out  = r.dqs_out;
    assign byte_strobe_oe_n = {2{r.oe_n}};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_pd_entry: assert property (
        r.pwr == gdp_pkg::PWR_ACTIVE && sys_rise && !r.sync2.cke && cmd != gdp_pkg::CMD_REFRESH
        |=> r.pwr == gdp_pkg::PWR_DOWN)
        else $error("power-down not entered");
    chk_sr_exit: assert property (
        r.pwr == gdp_pkg::PWR_SELF && r.sync2.cke |=> r.pwr == gdp_pkg::PWR_ACTIVE)
        else $error("self-refresh exit missed");
    chk_sr_hold: assert property (
        r.pwr == gdp_pkg::PWR_SELF && !r.sync2.cke |=> r.pwr == gdp_pkg::PWR_SELF)
        else $error("self-refresh left without gate");
    chk_out_off: assert property (
        !r.sync2.cke |=> dq_oe_n == 16'hffff && byte_strobe_oe_n == 2'h3)
        else $error("outputs driven with gate low");
    chk_pd_deaf: assert property (
        r.pwr == gdp_pkg::PWR_DOWN |=> $stable(r.ref_cnt) && $stable(r.open_row))
        else $error("command taken in power-down");
    chk_rd_latency: assert property (
        $rose(r.drv) |-> r.rd_edges == lat && r.rd_beat == 4'h1)
        else $error("read data at wrong latency");
    chk_burst_len: assert property (
        r.drv |-> r.rd_beat >= 4'h1 && r.rd_beat <= bl)
        else $error("read burst overran length");
    chk_mask_write: assert property (
        r.wr_act && sedge[0] && r.sync2.mask[0] |-> !wr_en[0])
        else $error("masked byte written");
    chk_strobe_edge: assert property (
        r.drv && $past(r.drv) && $changed(r.rd_beat) |-> $changed(r.dqs_out))
        else $error("read strobe not toggled with data");
    chk_cmd_rise: assert property (
        $changed(r.open_row) |-> $past(sys_rise) && !$past(r.sync2.cs_n))
        else $error("row latched off a clock rise");
endmodule : gdp_front_end

// ---- gdp_front_end_tb.sv ----
// Self-checking bench of the DRAM pin front end and its register slave.
`timescale 1ns/10ps
module gdp_front_end_tb;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0]  r;
    } gdp_row_s;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h0;
    logic [7:0]  araddr = 8'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready = 1'b1;
    logic        rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, bank_select, byte_strobe_in, byte_strobe_out;
    logic [1:0]  byte_strobe_oe_n, write_byte_mask, rs;
    logic [31:0] rdata, rd;
    logic [12:0] addr_in;
    logic [15:0] dq_in, dq_out, dq_oe_n;
    logic        sys_clock_pair, clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_cmd_n;
    logic [15:0] mem [8];
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cycles = 0;
    gdp_row_s    rows [10] = '{
        '{1'b0, gdp_pkg::MODE_OFS, 32'h0, {25'h0, gdp_pkg::MODE_RESET}, gdp_pkg::RESP_OKAY},
        '{1'b0, gdp_pkg::STATUS_OFS, 32'h0, 32'h0, gdp_pkg::RESP_OKAY},
        '{1'b0, gdp_pkg::REFCNT_OFS, 32'h0, 32'h0, gdp_pkg::RESP_OKAY},
        '{1'b1, gdp_pkg::STATUS_OFS, 32'hff, 32'h0, gdp_pkg::RESP_OKAY},
        '{1'b0, gdp_pkg::STATUS_OFS, 32'h0, 32'h0, gdp_pkg::RESP_OKAY},
        '{1'b1, 8'h10, 32'h1, 32'h0, gdp_pkg::RESP_ERR},
        '{1'b0, 8'h10, 32'h0, 32'h0, gdp_pkg::RESP_ERR},
        '{1'b1, gdp_pkg::MODE_OFS, 32'h3a, 32'h0, gdp_pkg::RESP_OKAY},
        '{1'b0, gdp_pkg::MODE_OFS, 32'h0, 32'h3a, gdp_pkg::RESP_OKAY},
        '{1'b1, gdp_pkg::MODE_OFS, 32'h32, 32'h0, gdp_pkg::RESP_OKAY}
    };
    gdp_front_end #(.ROW_BITS(4), .COL_BITS(3)) i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .sys_clock_pair, .clk_gate, .chip_sel_n, .row_strobe_n, .col_strobe_n,
        .write_cmd_n, .addr_in, .bank_select, .dq_in, .dq_out, .dq_oe_n, .byte_strobe_in,
        .byte_strobe_out, .byte_strobe_oe_n, .write_byte_mask
    );
    gdp_ctl_model i_ctl (
        .aclk, .sys_clock_pair, .clk_gate, .chip_sel_n, .row_strobe_n, .col_strobe_n,
        .write_cmd_n, .addr_in, .bank_select, .dq_in, .dq_out, .dq_oe_n, .byte_strobe_in,
        .byte_strobe_out, .byte_strobe_oe_n, .write_byte_mask
    );
    always #12.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) r = bresp;
            done = bvalid;
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            d = rdata;
            r = rresp;
            done = rvalid;
        end
    endtask : axi_rd
    task automatic rd_chk(input int col, input int lat, input int bl, input logic intl);
        int k;
        int x;
        i_ctl.issue(4'h5, 13'(col), 2'h2, 1'b1);
        for (int n = 2; n <= lat + bl + 1; n++) begin
            i_ctl.half(1'b0);
            k = n - 1 - lat;
            x = (col & ~(bl - 1)) | ((intl ? col ^ k : col + k) & (bl - 1));
            if (k < 0 || k == bl) chk(32'h1, {31'h0, i_ctl.seen_oe});
            else chk({14'h0, {2{k[0] == 1'b0}}, mem[x]},
                     {i_ctl.seen_oe, i_ctl.seen_dqs, i_ctl.seen_dq});
        end
        // An odd count of halves would leave the clock high for the next command.
        if ((lat + bl) % 2 == 1) i_ctl.half(1'b0);
    endtask : rd_chk
    task automatic wr_burst(input int col, input int bl, input logic [15:0] b,
                            input logic [15:0] mk);
        logic [15:0] d;
        int x;
        i_ctl.issue(4'h4, 13'(col), 2'h2, 1'b1);
        for (int k = 0; k < bl; k++) begin
            d = b ^ 16'(k * 16'h1111);
            x = (col & ~(bl - 1)) | ((col + k) & (bl - 1));
            if (!mk[2*k]) mem[x][7:0] = d[7:0];
            if (!mk[2*k+1]) mem[x][15:8] = d[15:8];
            i_ctl.write(d, mk[2*k +: 2]);
        end
        i_ctl.wr_end();
    endtask : wr_burst
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rs);
            else axi_rd(rows[i].a, rd, rs);
            if (!rows[i].wr) chk(rows[i].e, rd);
            chk({30'h0, rows[i].r}, {30'h0, rs});
        end
        i_ctl.issue(4'h3, 13'h5, 2'h2, 1'b1);
        wr_burst(1, 4, 16'ha5c3, 16'h0);
        rd_chk(2, 6, 4, 1'b0);
        axi_wr(gdp_pkg::MODE_OFS, 32'h3a, rs);
        rd_chk(1, 6, 4, 1'b1);
        i_ctl.issue(4'h8, 13'h61, 2'h0, 1'b1);
        axi_rd(gdp_pkg::MODE_OFS, rd, rs);
        chk(32'h3a, rd);
        i_ctl.issue(4'h0, 13'h61, 2'h0, 1'b1);
        axi_rd(gdp_pkg::MODE_OFS, rd, rs);
        chk(32'h61, rd);
        wr_burst(0, 2, 16'h3c96, 16'h0009);
        rd_chk(0, 5, 2, 1'b0);
        rd_chk(3, 5, 2, 1'b0);
        i_ctl.issue(4'h1, 13'h0, 2'h0, 1'b1);
        axi_rd(gdp_pkg::REFCNT_OFS, rd, rs);
        chk(32'h1, rd);
        i_ctl.issue(4'hf, 13'h0, 2'h0, 1'b0);
        axi_rd(gdp_pkg::STATUS_OFS, rd, rs);
        chk(32'h1, rd);
        i_ctl.issue(4'h0, 13'h31, 2'h0, 1'b0);
        i_ctl.issue(4'hf, 13'h0, 2'h0, 1'b1);
        axi_rd(gdp_pkg::MODE_OFS, rd, rs);
        chk(32'h61, rd);
        axi_rd(gdp_pkg::STATUS_OFS, rd, rs);
        chk(32'h0, rd);
        i_ctl.issue(4'h1, 13'h0, 2'h0, 1'b0);
        axi_rd(gdp_pkg::STATUS_OFS, rd, rs);
        chk(32'h2, rd);
        i_ctl.issue(4'h0, 13'h32, 2'h0, 1'b0);
        i_ctl.lift();
        repeat (6) @(posedge aclk);
        axi_rd(gdp_pkg::STATUS_OFS, rd, rs);
        chk(32'h0, rd);
        axi_rd(gdp_pkg::MODE_OFS, rd, rs);
        chk(32'h61, rd);
        // A second reset in mid-run restores the mode and releases the bus.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'h3ffff, {14'h0, dq_oe_n, byte_strobe_oe_n});
        axi_rd(gdp_pkg::MODE_OFS, rd, rs);
        chk({25'h0, gdp_pkg::MODE_RESET}, rd);
        complete_run();
    end
endmodule : gdp_front_end_tb

// ---- gdp_pkg.sv ----
// Constants, types and the state record of the DRAM front end.
// Behaviour
// - Commands on clock rise, data on strobe edges.
// - Clock gate low stops clock, enters low power.
// - Gate sampled on edges for power-down and self-refresh entry.
// - Self-refresh exit and output disable need no edge.
// - Power-down observes only clock and gate.
// - Self-refresh observes only the gate.
// - Read latency 2.5 or 3 clocks.
// - Burst length 2, 4 or 8.
// - Sequential or interleaved burst ordering.
// - Four banks of 16-bit words.
// - Masks block write bytes, never read data.
// - One beat per strobe edge, both directions.
// - Two strobes, one per byte lane.
// - Read strobe edges aligned with data.
// - Outputs change on system clock edges.
// - Chip select high ignores new commands.
// - Low lane bits 0-7, high lane 8-15.
// - Mask acts on the beat it accompanies.
// - Row and column latched with their strobes low.
package gdp_pkg;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam logic [7:0] MODE_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] REFCNT_OFS = 8'h08;
    localparam logic [6:0] MODE_RESET = 7'h32;
    localparam logic [2:0] BL2_CODE   = 3'h1;
    localparam logic [2:0] BL4_CODE   = 3'h2;
    localparam logic [2:0] CL25_CODE  = 3'h6;
    localparam logic [3:0] LAT25_HALF = 4'h5;
    localparam logic [3:0] LAT3_HALF  = 4'h6;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF} gdp_pwr_e;
    typedef enum logic [2:0] {CMD_NOP, CMD_MODE_REG_SET, CMD_REFRESH, CMD_PRECHARGE,
                              CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_STOP} gdp_cmd_e;

    typedef struct packed {
        logic [2:0] lat_code;
        logic       bt;
        logic [2:0] bl;
    } gdp_mode_s;

    typedef struct packed {
        logic        sys_clk;
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [12:0] addr;
        logic [1:0]  bank;
        logic [15:0] dq;
        logic [1:0]  dqs;
        logic [1:0]  mask;
    } gdp_pin_s;

    typedef struct packed {
        gdp_pin_s              sync1;
        gdp_pin_s              sync2;
        logic                  sys_clk_prev;
        logic [1:0]            dqs_prev;
        gdp_pwr_e              pwr;
        gdp_mode_s             mode;
        logic [3:0][ROW_W-1:0] open_row;
        logic [15:0]           ref_cnt;
        logic                  wr_act;
        logic [1:0]            wr_bank;
        logic [ROW_W-1:0]      wr_row;
        logic [COL_W-1:0]      wr_col;
        logic [1:0][3:0]       wr_beat;
        logic                  rd_act;
        logic [1:0]            rd_bank;
        logic [ROW_W-1:0]      rd_row;
        logic [COL_W-1:0]      rd_col;
        logic [3:0]            rd_edges;
        logic [3:0]            rd_beat;
        logic                  drv;
        logic [15:0]           dq_out;
        logic [1:0]            dqs_out;
        logic                  oe_n;
        logic                  aw_got;
        logic [7:0]            aw_addr;
        logic                  w_got;
        logic [31:0]           w_data;
        logic                  w_strb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } gdp_state_s;
endpackage : gdp_pkg
